/* src/tcw_defs.vh */
// Purpose: Constants for the 8-bit timer compare waveform unit
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
`ifndef TCW_DEFS_VH
`define TCW_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TCW_AW          8
`define TCW_OFS_CTRL    8'h00
`define TCW_OFS_COUNT   8'h04
`define TCW_OFS_COMPARE 8'h08
`define TCW_OFS_FLAGS   8'h0c
`define TCW_OFS_STATUS  8'h10

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define TCW_CTRL_WGM_LO 0
`define TCW_CTRL_WGM_HI 1
`define TCW_CTRL_COM_LO 2
`define TCW_CTRL_COM_HI 3
`define TCW_CTRL_FORCE  4
`define TCW_FLAG_OVF    0
`define TCW_FLAG_CMP    1

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define TCW_WGM_NORMAL  2'h0
`define TCW_WGM_PHASE   2'h1
`define TCW_WGM_CTC     2'h2
`define TCW_WGM_FAST    2'h3
`define TCW_COM_OFF     2'h0
`define TCW_COM_TOGGLE  2'h1
`define TCW_COM_CLEAR   2'h2
`define TCW_COM_SET     2'h3
`define TCW_CNT_MAX     8'hff
`define TCW_CNT_BOTTOM  8'h00
`define TCW_RST_BYTE    8'h00
`define TCW_RST_MODE    2'h0
`define TCW_RST_OC      1'b0

`endif

/* src/tcw_timer8.v */
// Purpose: 8-bit timer counter with compare output and waveform modes
// Assumes: timer_tick is a one-cycle enable from an external prescaler
// Notes:   All state, bus included, holds while clk_en is low
//          Phase-correct encoding idles here: no count, no output
//
// Function
// - Reset clears output state to zero
// - Nonzero output mode overrides port output value
// - Override ignores waveform mode
// - Output mode zero leaves state unchanged
// - Mode change acts at match; force acts now
// - Waveform mode alone picks count sequence
// - Normal mode increments and wraps only
// - Normal overflow set as counter becomes zero
// - Counter writable anytime in normal mode
// - Clear-on-match mode clears counter at compare
// - Compare flag marks each arrival at top
// - Unbuffered compare below count wraps first
// - Output mode one toggles on match
// - Toggle frequency set by compare value
// - Clear-on-match overflow on max to zero
// - Fast mode counts to max then clears
// - Fast mode polarity: clear/set at match, bottom
// - Fast mode overflow set at max
// - Fast period is 256 timer ticks
// - Extremes give spike or constant level
// - Match sets compare flag; one clears
// - Compare double buffered in PWM modes
// - Non-PWM force updates output, no flag, no clear
// - Counter write blocks next tick's match
`timescale 1ns/100ps
`include "tcw_defs.vh"

module tcw_timer8 (
  input  wire                  pclk,
  input  wire                  presetn,
  input  wire                  clk_en,
  input  wire                  timer_tick,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [`TCW_AW-1:0]    paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  input  wire                  overflow_service,
  input  wire                  compare_service,
  input  wire                  port_out_bit,
  input  wire                  output_pin_direction_bit,
  output reg                   pin_out,
  output reg                   pin_oe_n,
  output reg                   overflow_flag,
  output reg                   compare_match_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [1:0] waveform_mode;
  reg [1:0] compare_output_mode;
  reg [7:0] count_value;
  reg [7:0] compare_value;
  reg [7:0] compare_buffer;
  reg       compare_output_state;
  reg       match_block;

  reg [7:0] next_count;
  reg [7:0] next_compare;
  reg       next_oc;
  reg       next_ovf;
  reg       next_cmp;
  reg       next_block;
  // Next values and single-cycle events
  reg [31:0] next_prdata;
  reg       next_pin_out;
  reg       ovf_set;
  reg       cmp_set;
  reg       ovf_clr;
  reg       cmp_clr;

  wire      access;
  wire      wr_en;
  wire      rd_sel;
  wire      tick;
  wire      pwm_mode;
  wire      at_max;
  wire      match;
  wire      wr_ctrl;
  wire      wr_count;
  wire      wr_compare;
  wire      wr_flags;
  wire      force_req;
  wire      addr_ok;
  wire      sel_ctrl;
  wire      sel_count;
  wire      sel_compare;
  wire      sel_flags;
  wire      sel_status;

  // Outcome of one compare action on the output state
  function action;
    input [1:0] mode;
    input       cur;
    begin
      case (mode)
        `TCW_COM_TOGGLE: action = ~cur;
        `TCW_COM_CLEAR:  action = 1'b0;
        `TCW_COM_SET:    action = 1'b1;
        default:         action = cur;
      endcase
    end
  endfunction

  // True for the modes where the compare value is written straight through
  function non_pwm;
    input [1:0] mode;
    begin
      non_pwm = (mode == `TCW_WGM_NORMAL) || (mode == `TCW_WGM_CTC);
    end
  endfunction

  // Word select for one register offset
  function hit;
    input [`TCW_AW-1:0] addr;
    input [`TCW_AW-1:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second cycle of the access phase
  assign access  = psel & penable;
  assign wr_en   = access & pready & pwrite & clk_en;
  assign rd_sel  = access & ~pready & ~pwrite;

  assign sel_ctrl    = hit(paddr, `TCW_OFS_CTRL);
  assign sel_count   = hit(paddr, `TCW_OFS_COUNT);
  assign sel_compare = hit(paddr, `TCW_OFS_COMPARE);
  assign sel_flags   = hit(paddr, `TCW_OFS_FLAGS);
  assign sel_status  = hit(paddr, `TCW_OFS_STATUS);
  // Unmapped words answer with an error and never write
  assign addr_ok = sel_ctrl | sel_count | sel_compare | sel_flags |
                   sel_status;

  // Write strobes fire only at the completing edge of an access
  assign wr_ctrl    = wr_en & sel_ctrl;
  assign wr_count   = wr_en & sel_count;
  assign wr_compare = wr_en & sel_compare;
  assign wr_flags   = wr_en & sel_flags;

  // Force only acts in the non-PWM modes
  assign force_req = wr_ctrl & pwdata[`TCW_CTRL_FORCE] &
                     non_pwm(pwdata[`TCW_CTRL_WGM_HI:`TCW_CTRL_WGM_LO]);

  // Read word picked here and captured with pready, zero otherwise
  always @* begin
    next_prdata = 32'h0000_0000;
    if (rd_sel) begin
      if (sel_ctrl)
        next_prdata = {28'h000_0000, compare_output_mode, waveform_mode};
      else if (sel_count)
        next_prdata = {24'h00_0000, count_value};
      else if (sel_compare)
        next_prdata = {24'h00_0000, compare_buffer};
      else if (sel_flags)
        next_prdata = {30'h0000_0000, compare_match_flag, overflow_flag};
      else if (sel_status)
        next_prdata = {16'h0000, compare_value, 7'h00,
                       compare_output_state};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~addr_ok;
      prdata  <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Counter and compare
  // ----------------------------------------------------------------
  assign tick     = timer_tick & clk_en;
  assign pwm_mode = ~non_pwm(waveform_mode);
  assign at_max   = (count_value == `TCW_CNT_MAX);
  // Equality only, so a compare set below the count waits for a wrap
  assign match    = (count_value == compare_value) & ~match_block;

  always @* begin
    next_count   = count_value;
    next_oc      = compare_output_state;
    next_ovf     = overflow_flag;
    next_cmp     = compare_match_flag;
    next_block   = match_block;

    if (tick) begin
      next_block = 1'b0;
      case (waveform_mode)
        `TCW_WGM_NORMAL: begin
          next_count = count_value + 8'h01;
          if (at_max)
            next_ovf = 1'b1;
          if (match) begin
            next_cmp = 1'b1;
            next_oc  = action(compare_output_mode,
                              compare_output_state);
          end
        end
        `TCW_WGM_CTC: begin
          if (match)
            next_count = `TCW_CNT_BOTTOM;
          else
            next_count = count_value + 8'h01;
          if (at_max)
            next_ovf = 1'b1;
          if (match) begin
            next_cmp = 1'b1;
            next_oc  = action(compare_output_mode,
                              compare_output_state);
          end
        end
        `TCW_WGM_FAST: begin
          // Wraps every 256 ticks whatever the compare value
          next_count = count_value + 8'h01;
          if (match) begin
            next_cmp = 1'b1;
            next_oc  = action(compare_output_mode,
                              compare_output_state);
          end
          if (at_max) begin
            next_ovf     = 1'b1;
            // Bottom action after match: compare at max stays constant
            if (compare_output_mode == `TCW_COM_CLEAR)
              next_oc = 1'b1;
            else if (compare_output_mode == `TCW_COM_SET)
              next_oc = 1'b0;
          end
        end
        default: begin
          next_count = count_value;
        end
      endcase
    end

    // Bus writes win over any count or clear in the same cycle
    if (wr_count) begin
      next_count = pwdata[7:0];
      next_block = 1'b1;
    end
    if (force_req)
      next_oc = action(pwdata[`TCW_CTRL_COM_HI:`TCW_CTRL_COM_LO],
                       compare_output_state);
    if (ovf_clr && !ovf_set)
      next_ovf = 1'b0;
    if (cmp_clr && !cmp_set)
      next_cmp = 1'b0;
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle, so no event is lost
  always @* begin
    ovf_set = 1'b0;
    cmp_set = 1'b0;
    if (tick && waveform_mode != `TCW_WGM_PHASE) begin
      ovf_set = at_max;
      cmp_set = match;
    end
    ovf_clr = (wr_flags & pwdata[`TCW_FLAG_OVF]) | overflow_service;
    cmp_clr = (wr_flags & pwdata[`TCW_FLAG_CMP]) | compare_service;
  end

  // ----------------------------------------------------------------
  // Active compare value
  // ----------------------------------------------------------------
  always @* begin
    next_compare = compare_value;
    // Fast mode reloads at top only, so no odd-length pulse appears
    if (tick && waveform_mode == `TCW_WGM_FAST && at_max)
      next_compare = compare_buffer;
    if (wr_compare && !pwm_mode)
      next_compare = pwdata[7:0];
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_mode       <= `TCW_RST_MODE;
      compare_output_mode <= `TCW_COM_OFF;
      compare_buffer      <= `TCW_RST_BYTE;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        waveform_mode       <= pwdata[`TCW_CTRL_WGM_HI:`TCW_CTRL_WGM_LO];
        compare_output_mode <= pwdata[`TCW_CTRL_COM_HI:`TCW_CTRL_COM_LO];
      end
      if (wr_compare)
        compare_buffer <= pwdata[7:0];
    end
  end

  // Counter and its one-tick match block
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= `TCW_RST_BYTE;
      match_block <= 1'b0;
    end else if (clk_en) begin
      count_value <= next_count;
      match_block <= next_block;
    end
  end

  // Output state survives mode changes; only a match, the fast-mode action at max, a force or reset changes it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value        <= `TCW_RST_BYTE;
      compare_output_state <= `TCW_RST_OC;
    end else if (clk_en) begin
      compare_value        <= next_compare;
      compare_output_state <= next_oc;
    end
  end

  // Sticky flags: only a one written back or a service clears them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag      <= 1'b0;
      compare_match_flag <= 1'b0;
    end else if (clk_en) begin
      overflow_flag      <= next_ovf;
      compare_match_flag <= next_cmp;
    end
  end

  // ----------------------------------------------------------------
  // Port pin override
  // ----------------------------------------------------------------
  // The pin follows the state only while an output mode is chosen;
  // direction stays with the port bit in every mode
  always @* begin
    if (compare_output_mode != `TCW_COM_OFF)
      next_pin_out = compare_output_state;
    else
      next_pin_out = port_out_bit;
  end

  // Registered, so the pin lags the output state by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      pin_out  <= next_pin_out;
      pin_oe_n <= ~output_pin_direction_bit;
    end
  end

endmodule // tcw_timer8

/* verification/tcw_load.sv */
// Purpose: External load on the compare output pin
// Assumes: The pin is released while pin_oe_n is high
// Notes:   Pull-down, so a released pin never shows the last value
`timescale 1ns/100ps
module tcw_load (
  input  wire pin_out,
  input  wire pin_oe_n,
  output wire pad
);
  assign pad = pin_oe_n ? 1'b0 : pin_out;
endmodule // tcw_load

/* verification/tcw_timer8_sva.sv */
// Purpose: Port-level checker for the timer compare unit
// Assumes: Mode fields change only through APB writes to CTRL
// Notes:   Counting itself is judged by the bench through readback
`timescale 1ns/100ps
`include "tcw_defs.vh"
module tcw_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        clk_en,
  input wire        timer_tick,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        overflow_service,
  input wire        compare_service,
  input wire        port_out_bit,
  input wire        output_pin_direction_bit,
  input wire        pin_out,
  input wire        pin_oe_n,
  input wire        overflow_flag,
  input wire        compare_match_flag
);
  reg  [3:0] ctl;
  wire       wr_ok = psel && penable && pready && pwrite && clk_en;
  wire       flg_wr = wr_ok && paddr == `TCW_OFS_FLAGS;
  // Shadow of the mode fields, updated at the same edge as the design
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctl <= 4'h0;
    else if (wr_ok && paddr == `TCW_OFS_CTRL)
      ctl <= pwdata[3:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmp_w1c;
    flg_wr && pwdata[1] && !timer_tick;
  endsequence
  sequence s_phase_idle;
    ctl[1:0] == `TCW_WGM_PHASE && !overflow_flag;
  endsequence
  AST_RST_CLEAR: assert property (disable iff (1'b0)
    !presetn |-> !pin_out && !overflow_flag && !compare_match_flag)
    else $error("state not cleared in reset");
  AST_PORT_PASS: assert property (
    clk_en && ctl[3:2] == `TCW_COM_OFF |=> pin_out == $past(port_out_bit))
    else $error("port value not passed to pin");
  AST_PIN_DIR: assert property (
    clk_en |=> pin_oe_n == !$past(output_pin_direction_bit))
    else $error("pin drive enable wrong");
  AST_OVF_TICK: assert property (
    $rose(overflow_flag) |-> $past(timer_tick && clk_en))
    else $error("overflow set without tick");
  AST_CMP_TICK: assert property (
    $rose(compare_match_flag) |-> $past(timer_tick && clk_en))
    else $error("compare flag set without tick");
  AST_OVF_HOLD: assert property (
    $fell(overflow_flag) |-> $past(overflow_service || flg_wr && pwdata[0]))
    else $error("overflow cleared by itself");
  AST_CMP_HOLD: assert property (
    $fell(compare_match_flag) |->
      $past(compare_service || flg_wr && pwdata[1]))
    else $error("compare flag cleared by itself");
  AST_CMP_W1C: assert property (s_cmp_w1c |=> !compare_match_flag)
    else $error("compare flag not cleared");
  AST_PHASE_IDLE: assert property (s_phase_idle |=> !overflow_flag)
    else $error("overflow set in idle mode");
endmodule // tcw_chk

bind tcw_timer8 tcw_chk tcw_chk_i (
  .pclk, .presetn, .clk_en, .timer_tick, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .overflow_service, .compare_service, .port_out_bit,
  .output_pin_direction_bit, .pin_out, .pin_oe_n, .overflow_flag,
  .compare_match_flag
);

/* verification/testbench.sv */
// Purpose: Self-checking bench for the timer compare unit
// Assumes: clk_en held high; one timer tick per pclk while ticking
// Notes:   Output state and active compare read back through STATUS
`timescale 1ns/100ps
`include "tcw_defs.vh"
module testbench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b1;
  reg         clk_en = 1'b1;
  reg         timer_tick = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         overflow_service = 1'b0;
  reg         compare_service = 1'b0;
  reg         port_out_bit = 1'b0;
  reg         output_pin_direction_bit = 1'b0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        pin_out;
  wire        pin_oe_n;
  wire        overflow_flag;
  wire        compare_match_flag;
  wire        pad;
  integer     n_errors = 0;
  integer     total_checks = 0;
  reg  [31:0] rd;
  reg         err;

  always #5 pclk = ~pclk;

  tcw_timer8 tcw_timer8_i (
    .pclk, .presetn, .clk_en, .timer_tick, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .overflow_service,
    .compare_service, .port_out_bit, .output_pin_direction_bit, .pin_out,
    .pin_oe_n, .overflow_flag, .compare_match_flag
  );
  tcw_load tcw_load_i (.pin_out, .pin_oe_n, .pad);

  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // A missing pready ends the run rather than hanging it
  task apb(input w, input [7:0] a, input [31:0] d);
    integer i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i = i + 1;
    end while (pready !== 1'b1 && i < 8);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task ticks(input integer n);
    @(posedge pclk);
    timer_tick <= 1'b1;
    repeat (n) @(posedge pclk);
    timer_tick <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    reg [7:0] a;
    for (a = 8'h00; a < 8'h18; a = a + 8'h04) begin
      rdc(a, 32'h0);
      chk({31'h0, err}, {31'h0, a == 8'h14});
    end
    $display("reset test done");
  endtask
  task t_normal;
    port_out_bit <= 1'b1;
    output_pin_direction_bit <= 1'b1;
    wr(`TCW_OFS_COUNT, 32'hfe);
    ticks(1);
    rdc(`TCW_OFS_FLAGS, 32'h0);
    ticks(1);
    rdc(`TCW_OFS_COUNT, 32'h0);
    rdc(`TCW_OFS_FLAGS, 32'h1);
    chk({31'h0, pad}, 32'h1);
    wr(`TCW_OFS_COUNT, 32'h0);
    ticks(1);
    rdc(`TCW_OFS_FLAGS, 32'h1);
    @(posedge pclk) overflow_service <= 1'b1;
    @(posedge pclk) overflow_service <= 1'b0;
    output_pin_direction_bit <= 1'b0;
    rdc(`TCW_OFS_FLAGS, 32'h0);
    chk({31'h0, pad}, 32'h0);
    chk({31'h0, pin_oe_n}, 32'h1);
    $display("normal test done");
  endtask
  task t_ctc;
    wr(`TCW_OFS_COMPARE, 32'h3);
    wr(`TCW_OFS_CTRL, 32'h6);
    ticks(4);
    rdc(`TCW_OFS_COUNT, 32'h1);
    rdc(`TCW_OFS_STATUS, 32'h301);
    rdc(`TCW_OFS_FLAGS, 32'h2);
    ticks(4);
    rdc(`TCW_OFS_STATUS, 32'h300);
    wr(`TCW_OFS_CTRL, 32'h16);
    rdc(`TCW_OFS_STATUS, 32'h301);
    wr(`TCW_OFS_CTRL, 32'h1a);
    rdc(`TCW_OFS_STATUS, 32'h300);
    rdc(`TCW_OFS_COUNT, 32'h1);
    @(posedge pclk) compare_service <= 1'b1;
    @(posedge pclk) compare_service <= 1'b0;
    rdc(`TCW_OFS_FLAGS, 32'h0);
    $display("clear-on-match test done");
  endtask
  task t_fast;
    output_pin_direction_bit <= 1'b1;
    wr(`TCW_OFS_FLAGS, 32'h3);
    wr(`TCW_OFS_CTRL, 32'hb);
    wr(`TCW_OFS_COMPARE, 32'h10);
    wr(`TCW_OFS_COUNT, 32'hfe);
    rdc(`TCW_OFS_STATUS, 32'h300);
    ticks(2);
    rdc(`TCW_OFS_STATUS, 32'h1001);
    rdc(`TCW_OFS_FLAGS, 32'h1);
    chk({31'h0, pad}, 32'h1);
    ticks(17);
    rdc(`TCW_OFS_STATUS, 32'h1000);
    chk({31'h0, pad}, 32'h0);
    wr(`TCW_OFS_FLAGS, 32'h1);
    rdc(`TCW_OFS_FLAGS, 32'h2);
    ticks(239);
    rdc(`TCW_OFS_STATUS, 32'h1001);
    rdc(`TCW_OFS_FLAGS, 32'h3);
    chk({30'h0, compare_match_flag, overflow_flag}, 32'h3);
    $display("fast test done");
  endtask
  task t_phase;
    wr(`TCW_OFS_FLAGS, 32'h3);
    wr(`TCW_OFS_CTRL, 32'h1);
    wr(`TCW_OFS_COUNT, 32'h5);
    ticks(3);
    rdc(`TCW_OFS_COUNT, 32'h5);
    rdc(`TCW_OFS_FLAGS, 32'h0);
    $display("idle mode test done");
  endtask

  initial begin
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_normal;
    t_ctc;
    t_fast;
    t_phase;
    report_and_stop;
  end
endmodule // testbench
